// File: rtl/vppa_regs.svh
// register offsets, field positions and fixed values of the emulated partner ability
// assumes inclusion by the design file, the checker and the bench of this block
`ifndef VPPA_REGS_SVH
`define VPPA_REGS_SVH

`define VPPA_ADV_OFFSET 12'h1D0
`define VPPA_LP_OFFSET 12'h1D4
`define VPPA_ADV_INDEX 5'h04
`define VPPA_LP_INDEX 5'h05

`define VPPA_NP_BIT 15
`define VPPA_ACK_BIT 14
`define VPPA_RF_BIT 13
`define VPPA_ASYM_BIT 11
`define VPPA_SYM_BIT 10
`define VPPA_T4_BIT 9
`define VPPA_ABIL_HI 8
`define VPPA_ABIL_LO 5
`define VPPA_SEL_HI 4
`define VPPA_SEL_LO 0

`define VPPA_SEL_8023 5'h01
`define VPPA_ABIL_10FD 4'h2
`define VPPA_ABIL_100FD 4'h8
`define VPPA_ABIL_10HD 4'h1
`define VPPA_ABIL_100HD 4'h4
`define VPPA_ABIL_NONE 4'h0
`define VPPA_ABIL_ALL 4'hF
`define VPPA_WORD_ZERO 16'h0000
`define VPPA_REG_W 16
`define VPPA_RDATA_ZERO 32'h0000_0000

`define VPPA_SER_IDX_HI 4
`define VPPA_SER_IDX_LO 0
`define VPPA_SER_PAGE_LO 5
`define VPPA_ADDR_HI 11
`define VPPA_SER_PAGE_ZERO 7'h00

`define VPPA_PAUSE_NONE 2'h0
`define VPPA_PAUSE_SYM 2'h1
`define VPPA_PAUSE_ASYM 2'h2
`define VPPA_PAUSE_BOTH 2'h3

`define VPPA_NP_VAL 1'h0
`define VPPA_ACK_VAL 1'h1
`define VPPA_RF_VAL 1'h0
`define VPPA_T4_VAL 1'h0
`define VPPA_RSVD_VAL 1'h0

`endif

// File: rtl/vppa_pkg.sv
// types shared by the emulated partner ability block
// assumes vppa_regs.svh sits on the include path
package vppa_pkg;

   // straps latched at reset release
   typedef struct packed {
      logic speed;
      logic duplex_pol;
      logic flow_choice;
      logic manual_fc;
   } vppa_strap_type;

   // one management access, either 32-bit view or serial 16-bit view
   typedef struct packed {
      logic rd;
      logic wr;
      logic serial;
      logic [11:0] addr;
      logic [15:0] wdata;
   } vppa_mgmt_req_type;

endpackage : vppa_pkg

// File: rtl/vppa_partner_ability.sv
// emulated link-partner base-page ability word and the local advertisement word
// assumes the auto-negotiation sequencer pulses an_complete and all inputs are on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "vppa_regs.svh"

// Functional notes
// - partner ability word is read-only; writes never change it.
// - bit 15 always reads 0, no next page.
// - bit 14 always reads 1, code word acknowledged immediately.
// - bit 13 always reads 0, no remote fault.
// - bit 9 always reads 0, no 100BASE-T4.
// - selector bits 4:0 read fixed 00001.
// - bits 31:16 read zero; serial view is 16 bits wide.
// - partner pause bits follow local pause advertisement per table.
// - both advertised: strap 1 gives both set, else asymmetric only.
// - pause bits computed only at auto-negotiation completion and once just after reset release.
// - pin equals polarity strap: full duplex, 0010 or 1000 by speed strap.
// - pin differs from polarity strap: half duplex, 0001 or 0100.
// - speed and duplex bits also depend on negotiation success.
// - speed, polarity and flow choice straps latched once at reset release.
// - advertisement holds asymmetric pause bit 11, symmetric bit 10, writable.
// - negotiation fails when advertised and partner abilities share no bits.
module vppa_partner_ability
   import vppa_pkg::*;
(
   input wire logic ref_clk, // system clock, 250 MHz
   input wire logic rst, // synchronous reset, active high
   input wire vppa_mgmt_req_type mgmt_req, // management access
   output logic [31:0] mgmt_rdata, // read data, one cycle after rd
   input wire logic port_zero_duplex_pin, // duplex pin level
   input wire logic speed_strap, // speed strap level
   input wire logic duplex_pol_strap, // duplex polarity strap level
   input wire logic flow_choice_strap, // flow-control choice strap level
   input wire logic manual_fc_strap, // manual flow-control strap level
   input wire logic an_complete, // pulse: negotiation process completes
   output logic an_ok // negotiation succeeded
);

   // ==========================================================
   // helpers
   // ==========================================================
   // partner pause bits as {asym, sym} from the local advertisement
   function automatic logic [1:0] pause_of(
      input logic sym, // local symmetric pause
      input logic asym, // local asymmetric pause
      input logic choice // latched flow-control choice strap
   );
      logic [1:0] r;
      r = `VPPA_PAUSE_NONE;
      unique case ({sym, asym})
         2'h0: begin
            r = `VPPA_PAUSE_NONE;
         end
         2'h2: begin
            r = `VPPA_PAUSE_SYM;
         end
         2'h1: begin
            r = `VPPA_PAUSE_BOTH;
         end
         2'h3: begin
            r = choice ? `VPPA_PAUSE_BOTH : `VPPA_PAUSE_ASYM;
         end
      endcase
      return r;
   endfunction : pause_of

   // partner speed and duplex bits from the duplex pin and latched straps
   function automatic logic [3:0] abil_of(
      input logic pin, // duplex pin level
      input logic pol, // latched duplex polarity strap
      input logic spd // latched speed strap
   );
      logic [3:0] r;
      r = `VPPA_ABIL_NONE;
      unique case ({pin == pol, spd})
         2'h3: begin
            r = `VPPA_ABIL_100FD;
         end
         2'h2: begin
            r = `VPPA_ABIL_10FD;
         end
         2'h1: begin
            r = `VPPA_ABIL_100HD;
         end
         2'h0: begin
            r = `VPPA_ABIL_10HD;
         end
      endcase
      return r;
   endfunction : abil_of

   // address match in the 32-bit offset view or the serial index view
   function automatic logic hit(
      input logic [11:0] addr, // management address
      input logic serial, // serial view selected
      input logic [11:0] off, // byte offset of the register
      input logic [4:0] idx // serial index of the register
   );
      logic match;
      match = (addr == off);
      if (serial) begin
         match = (addr[`VPPA_SER_IDX_HI:`VPPA_SER_IDX_LO] == idx)
                 && (addr[`VPPA_ADDR_HI:`VPPA_SER_PAGE_LO] == `VPPA_SER_PAGE_ZERO);
      end
      return match;
   endfunction : hit

   // one 16-bit ability word from its fields; reserved bits read zero
   function automatic logic [15:0] word_of(
      input logic np, // next page
      input logic ack, // acknowledge
      input logic rf, // remote fault
      input logic asym, // asymmetric pause
      input logic sym, // symmetric pause
      input logic t4, // 100BASE-T4
      input logic [3:0] abil, // speed and duplex bits
      input logic [4:0] sel // selector
   );
      logic [15:0] w;
      w = `VPPA_WORD_ZERO;
      w[`VPPA_NP_BIT] = np;
      w[`VPPA_ACK_BIT] = ack;
      w[`VPPA_RF_BIT] = rf;
      w[`VPPA_ASYM_BIT] = asym;
      w[`VPPA_SYM_BIT] = sym;
      w[`VPPA_T4_BIT] = t4;
      w[`VPPA_ABIL_HI:`VPPA_ABIL_LO] = abil;
      w[`VPPA_SEL_HI:`VPPA_SEL_LO] = sel;
      return w;
   endfunction : word_of

   // ==========================================================
   // strap latch at reset release
   // ==========================================================
   logic rst_prev_q, rst_prev_d;
   logic first_q, first_d;
   logic release_now;
   vppa_strap_type strap_q, strap_d;

   assign release_now = rst_prev_q & ~rst;

   always_comb begin
      rst_prev_d = rst;
      first_d = release_now;
      strap_d = strap_q;
      if (release_now) begin
         strap_d.speed = speed_strap;
         strap_d.duplex_pol = duplex_pol_strap;
         strap_d.flow_choice = flow_choice_strap;
         strap_d.manual_fc = manual_fc_strap;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rst_prev_q <= 1'b1;
         first_q <= 1'b0;
         strap_q <= '0;
      end else begin
         rst_prev_q <= rst_prev_d;
         first_q <= first_d;
         strap_q <= strap_d;
      end
   end

   // ==========================================================
   // local advertisement word
   // ==========================================================
   logic asym_adv_q, asym_adv_d;
   logic sym_adv_q, sym_adv_d;
   logic [3:0] abil_adv_q, abil_adv_d;
   logic [4:0] sel_adv_q, sel_adv_d;
   logic adv_hit;
   logic lp_hit;
   logic adv_wr;
   logic [15:0] adv_word;

   // one decode per register, shared by the write and read paths
   assign adv_hit = hit(mgmt_req.addr, mgmt_req.serial, `VPPA_ADV_OFFSET, `VPPA_ADV_INDEX);
   assign lp_hit = hit(mgmt_req.addr, mgmt_req.serial, `VPPA_LP_OFFSET, `VPPA_LP_INDEX);
   // only the advertisement decodes writes; the partner word has no write path
   assign adv_wr = mgmt_req.wr & adv_hit;

   always_comb begin
      asym_adv_d = asym_adv_q;
      sym_adv_d = sym_adv_q;
      abil_adv_d = abil_adv_q;
      sel_adv_d = sel_adv_q;
      if (first_q) begin
         // pause advertised unless manual flow control strapped
         asym_adv_d = ~strap_q.manual_fc;
         sym_adv_d = ~strap_q.manual_fc;
      end else if (adv_wr) begin
         asym_adv_d = mgmt_req.wdata[`VPPA_ASYM_BIT];
         sym_adv_d = mgmt_req.wdata[`VPPA_SYM_BIT];
         abil_adv_d = mgmt_req.wdata[`VPPA_ABIL_HI:`VPPA_ABIL_LO];
         sel_adv_d = mgmt_req.wdata[`VPPA_SEL_HI:`VPPA_SEL_LO];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         asym_adv_q <= 1'b0;
         sym_adv_q <= 1'b0;
         abil_adv_q <= `VPPA_ABIL_ALL;
         sel_adv_q <= `VPPA_SEL_8023;
      end else begin
         asym_adv_q <= asym_adv_d;
         sym_adv_q <= sym_adv_d;
         abil_adv_q <= abil_adv_d;
         sel_adv_q <= sel_adv_d;
      end
   end

   assign adv_word = word_of(`VPPA_NP_VAL, `VPPA_RSVD_VAL, `VPPA_RF_VAL, asym_adv_q,
                             sym_adv_q, `VPPA_T4_VAL, abil_adv_q, sel_adv_q);

   // ==========================================================
   // negotiation outcome
   // ==========================================================
   logic [1:0] lp_pause_q, lp_pause_d;
   logic an_ok_q, an_ok_d;
   logic an_run;
   logic [3:0] live_abil;

   assign an_run = first_q | an_complete;
   assign live_abil = abil_of(port_zero_duplex_pin, strap_q.duplex_pol, strap_q.speed);

   always_comb begin
      lp_pause_d = lp_pause_q;
      an_ok_d = an_ok_q;
      if (an_run) begin
         lp_pause_d = pause_of(sym_adv_q, asym_adv_q, strap_q.flow_choice);
         an_ok_d = (abil_adv_q & live_abil) != `VPPA_ABIL_NONE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lp_pause_q <= `VPPA_PAUSE_NONE;
         an_ok_q <= 1'b0;
      end else begin
         lp_pause_q <= lp_pause_d;
         an_ok_q <= an_ok_d;
      end
   end

   assign an_ok = an_ok_q;

   // ==========================================================
   // partner ability word and read path
   // ==========================================================
   logic [15:0] lp_word;
   logic [31:0] rdata_q, rdata_d;

   assign lp_word = word_of(`VPPA_NP_VAL,
                            `VPPA_ACK_VAL,
                            `VPPA_RF_VAL,
                            lp_pause_q[1],
                            lp_pause_q[0],
                            `VPPA_T4_VAL,
                            an_ok_q ? live_abil : `VPPA_ABIL_NONE,
                            `VPPA_SEL_8023);

   // registered read data; a read in a write cycle returns the old value
   always_comb begin
      rdata_d = rdata_q;
      if (mgmt_req.rd) begin
         rdata_d = `VPPA_RDATA_ZERO;
         if (lp_hit) begin
            rdata_d[`VPPA_REG_W-1:0] = lp_word;
         end else if (adv_hit) begin
            rdata_d[`VPPA_REG_W-1:0] = adv_word;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_q <= `VPPA_RDATA_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign mgmt_rdata = rdata_q;

   // ==========================================================
   // elaboration checks on the field layout
   // ==========================================================
   if (`VPPA_ABIL_HI - `VPPA_ABIL_LO + 1 != $bits(abil_adv_q)) begin : g_bad_abil
      $error("ability field width does not match its register");
   end
   if (`VPPA_SEL_HI - `VPPA_SEL_LO + 1 != $bits(sel_adv_q)) begin : g_bad_sel
      $error("selector field width does not match its register");
   end
   if (`VPPA_NP_BIT >= `VPPA_REG_W || $bits(lp_word) != `VPPA_REG_W) begin : g_bad_word
      $error("field layout does not fit the serial register width");
   end
   if ($bits(mgmt_rdata) < `VPPA_REG_W) begin : g_bad_rdata
      $error("read data narrower than one register");
   end

endmodule : vppa_partner_ability
`default_nettype wire

// File: testbench/vppa_monitor.sv
// checker of the partner ability read port
// assumes binding to the block top
`timescale 1ns/1ps
`default_nettype none
`include "vppa_regs.svh"
module vppa_monitor
   import vppa_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rst, // sync reset
   input wire vppa_mgmt_req_type mgmt_req, // access
   input wire logic [31:0] mgmt_rdata, // read data
   input wire logic an_complete, // run pulse
   input wire logic an_ok // run result
);
   logic lp;
   assign lp = mgmt_req.rd && (mgmt_req.serial ? mgmt_req.addr == 12'h005
      : mgmt_req.addr == `VPPA_LP_OFFSET);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_pad_zero: assert property (mgmt_rdata[31:16] == 16'h0000)
      else $error("pad bits set");
   chk_np_clear: assert property (lp |=> !mgmt_rdata[15])
      else $error("next page set");
   chk_ack_set: assert property (lp |=> mgmt_rdata[14])
      else $error("ack clear");
   chk_rf_clear: assert property (lp |=> !mgmt_rdata[13])
      else $error("fault set");
   chk_t4_clear: assert property (lp |=> !mgmt_rdata[9])
      else $error("t4 set");
   chk_sel_fixed: assert property (lp |=> mgmt_rdata[4:0] == 5'h01)
      else $error("bad selector");
   chk_fail_abil: assert property (lp && !an_ok |=> mgmt_rdata[8:5] == 4'h0)
      else $error("abilities on failure");
   chk_abil_onehot: assert property (lp && an_ok |=> $onehot(mgmt_rdata[8:5]))
      else $error("ability not one mode");
   chk_pause_frozen: assert property (lp && !an_complete ##1 lp |=>
      mgmt_rdata[11:10] == $past(mgmt_rdata[11:10])) else $error("pause moved");
endmodule : vppa_monitor
`default_nettype wire

// File: testbench/vppa_host_model.sv
// management host model issuing register accesses
// assumes the bench calls access
`timescale 1ns/1ps
`default_nettype none
module vppa_host_model
   import vppa_pkg::*;
(
   input wire logic ref_clk, // clock
   output var vppa_mgmt_req_type mgmt_req, // access
   input wire logic [31:0] mgmt_rdata // read data
);
   initial mgmt_req = '0;
   // hold one access for n edges, released lines scrambled
   task automatic access(input logic wr, input logic ser, input logic [11:0] a,
      input logic [15:0] d, input int n, output logic [31:0] q);
      @(posedge ref_clk) #1;
      mgmt_req = {!wr, wr, ser, a, d};
      repeat (n) @(posedge ref_clk);
      #1;
      q = mgmt_rdata;
      mgmt_req = {3'b000, ~a, ~d};
   endtask : access
endmodule : vppa_host_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench of the partner ability word
// assumes the host model and checker files
`timescale 1ns/1ps
`default_nettype none
`include "vppa_regs.svh"
module tb
   import vppa_pkg::*;
();
   typedef struct packed {
      logic [1:0] adv;
      logic pin;
      logic [1:0] pause;
      logic [3:0] abil;
   } vppa_row_type;
   logic ref_clk, rst, pin, spd, pol, choice, manual, an_go, an_ok;
   logic [31:0] rdata, got;
   vppa_mgmt_req_type req;
   int bad_count = 0;
   int checked = 0;
   vppa_row_type rows [4] = '{'{2'h0, 1'b0, 2'h0, 4'h8}, '{2'h1, 1'b1, 2'h1, 4'h4},
      '{2'h2, 1'b0, 2'h3, 4'h8}, '{2'h3, 1'b1, 2'h3, 4'h4}};
   vppa_partner_ability DUT (.ref_clk(ref_clk), .rst(rst), .mgmt_req(req), .mgmt_rdata(rdata),
      .port_zero_duplex_pin(pin), .speed_strap(spd), .duplex_pol_strap(pol),
      .flow_choice_strap(choice), .manual_fc_strap(manual), .an_complete(an_go), .an_ok(an_ok));
   vppa_host_model host (.ref_clk(ref_clk), .mgmt_req(req), .mgmt_rdata(rdata));
   function automatic logic [31:0] lpw(input logic [1:0] p, input logic [3:0] a);
      return {16'h0000, 4'h4, p, 1'b0, a, 5'h01};
   endfunction : lpw
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         bad_count++;
         $display("ERROR %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic rd(input logic [11:0] a, input logic ser, input int n);
      host.access(1'b0, ser, a, 16'h0000, n, got);
   endtask : rd
   task automatic adv(input logic [1:0] p, input logic [3:0] a);
      host.access(1'b1, 1'b0, `VPPA_ADV_OFFSET, {4'h0, p, 1'b0, a, 5'h01}, 1, got);
   endtask : adv
   task automatic run_an();
      @(posedge ref_clk) #1;
      an_go = 1'b1;
      @(posedge ref_clk) #1;
      an_go = 1'b0;
   endtask : run_an
   task automatic do_reset(input logic s, input logic c, input logic m);
      @(posedge ref_clk) #1;
      rst = 1'b1;
      spd = s;
      choice = c;
      manual = m;
      repeat (2) @(posedge ref_clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask : do_reset
   task automatic complete_run();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      #100000;
      bad_count++;
      complete_run();
   end
   initial begin
      {rst, pin, pol, an_go} = 4'b1000;
      do_reset(1'b1, 1'b1, 1'b0);
      rd(`VPPA_ADV_OFFSET, 1'b0, 1);
      check(got, {16'h0000, 4'h0, 2'h3, 1'h0, 4'hF, 5'h01});
      foreach (rows[i]) begin
         adv(rows[i].adv, 4'hF);
         pin = rows[i].pin;
         run_an();
         rd(`VPPA_LP_OFFSET, 1'b0, 1);
         check(got, lpw(rows[i].pause, rows[i].abil));
      end
      adv(2'h0, 4'hF);
      rd(`VPPA_LP_OFFSET, 1'b0, 2);
      check(got, lpw(2'h3, 4'h4));
      host.access(1'b1, 1'b0, `VPPA_LP_OFFSET, 16'h0000, 1, got);
      rd(12'h005, 1'b1, 1);
      check(got, lpw(2'h3, 4'h4));
      rd(12'h1E0, 1'b0, 1);
      check(got, 32'h0);
      {spd, choice, pol} = 3'b001;
      adv(2'h3, 4'hF);
      run_an();
      rd(`VPPA_LP_OFFSET, 1'b0, 1);
      check(got, lpw(2'h3, 4'h4));
      adv(2'h3, 4'h0);
      run_an();
      rd(`VPPA_LP_OFFSET, 1'b0, 1);
      check(got, lpw(2'h3, 4'h0));
      check({31'h0, an_ok}, 32'h0);
      adv(2'h3, 4'hF);
      run_an();
      rd(`VPPA_LP_OFFSET, 1'b0, 1);
      check(got, lpw(2'h3, 4'h4));
      check({31'h0, an_ok}, 32'h1);
      do_reset(1'b0, 1'b0, 1'b1);
      rd(`VPPA_ADV_OFFSET, 1'b0, 1);
      check(got, {16'h0000, 4'h0, 2'h0, 1'h0, 4'hF, 5'h01});
      host.access(1'b1, 1'b1, 12'h004, {4'h0, 2'h3, 1'b0, 4'hF, 5'h01}, 1, got);
      pin = 1'b1;
      run_an();
      rd(`VPPA_LP_OFFSET, 1'b0, 1);
      check(got, lpw(2'h2, 4'h2));
      pin = 1'b0;
      rd(`VPPA_LP_OFFSET, 1'b0, 1);
      check(got, lpw(2'h2, 4'h1));
      complete_run();
   end
endmodule : tb
bind vppa_partner_ability vppa_monitor mon (.ref_clk(ref_clk), .rst(rst), .mgmt_req(mgmt_req),
   .mgmt_rdata(mgmt_rdata), .an_complete(an_complete), .an_ok(an_ok));
`default_nettype wire
